// ==== src/bypass_control_word_sequencer.sv ====
// Purpose: Command word interpreter and start-up sequencer for the bypass node.
// Assumes: All inputs are synchronous to core_clk; the host writes whole 16-bit words.
// Notes: The settling counter only reports; an early write is still obeyed but marked.
//        The one unused state code recovers to not-ready rather than acting as a running state.

//Contract
// - Power-up enters not-ready-to-switch-on state.
// - Word 0x0006 moves to ready-to-switch-on.
// - Word 0x0007 from ready moves to ready-to-operate.
// - Word 0x000F enters operation enabled, no ramp.
// - Word 0x002F releases ramp, accelerator enabled.
// - Word 0x006F enters operating, tracks reference.
// - External fault reset also leaves fault state.
// - System mode ignores network starts to drive.
// - System mode routes start by bypass/drive mode.
// - System mode uses bypass profile; setting only ramp.
// - Bit 0 commands start, clear commands stop.
// - Bit 1 resets fault on rising edge only.
// - Bit 2 inverted run permissive; start still accepted.
// - Bit 3 requests network takeover of control.
// - Bits 4-7 interlocks block start acceptance.
// - Bit 8 selects second override function.
// - Bit 9 reads link state, not writable.
module bypass_control_word_sequencer #(
   parameter int SETTLE_COUNT = cw_seq_pkg::SETTLE_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cw_write,
   input wire logic [15:0] cw_write_data,
   input wire logic link_up,
   input wire logic fault_present,
   input wire logic ext_fault_reset,
   input wire logic system_mode,
   input wire logic bypass_mode,
   input wire logic drive_start_request,
   input wire logic drive_profile_ramp_hold,
   output logic [15:0] command_word_read,
   output logic [2:0] state_code,
   output logic settle_done,
   output logic early_write_seen,
   output logic ramp_generator_release,
   output logic ramp_generator_accel,
   output logic fault_reset_pulse,
   output logic run_permitted,
   output logic start_accepted,
   output logic network_takeover_request,
   output logic start_interlock_one_inhibit,
   output logic start_interlock_two_inhibit,
   output logic start_interlock_three_inhibit,
   output logic start_interlock_four_inhibit,
   output logic override_two_select,
   output logic bypass_start,
   output logic drive_start,
   output logic ramp_hold_out
);

   // Stored command word, holding only the writable bits.
   logic [15:0] cw_reg;
   logic [15:0] cw_next;

   // Sequencer state.
   cw_seq_pkg::seq_state_t state_reg;
   cw_seq_pkg::seq_state_t state_next;

   // Settling counter for the ready-to-switch-on dwell.
   logic [31:0] settle_cnt_reg;
   logic settle_done_reg;

   // Fault reset edges from the word and from the external source.
   logic cw_reset_edge;
   logic ext_reset_edge;
   logic any_reset;

   // Decoded command word fields.
   logic cmd_start;
   logic cmd_run_inhibit;
   logic [3:0] cmd_interlocks;
   logic interlock_missing;
   logic start_ok;
   logic run_ok;
   logic running_state;

   // Write data with the link bit and reserved bits masked off.
   always_comb begin
      cw_next = cw_reg;
      if (cw_write) begin
         cw_next = cw_write_data & cw_seq_pkg::WRITABLE_MASK;
      end
   end

   // Command word storage; starts cleared so no start is pending after power-up.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cw_reg <= cw_seq_pkg::CW_RESET;
      end else begin
         cw_reg <= cw_next;
      end
   end

   // Field decode from the stored word.
   assign cmd_start = cw_reg[cw_seq_pkg::BIT_START];
   assign cmd_run_inhibit = cw_reg[cw_seq_pkg::BIT_RUN_INHIBIT];
   assign cmd_interlocks = cw_reg[cw_seq_pkg::BIT_INTERLOCK_HI:cw_seq_pkg::BIT_INTERLOCK_LO];
   assign interlock_missing = |cmd_interlocks;

   // The fault reset bit acts only on its rising edge, so a steady one never resets twice.
   rise_pulse u_cw_reset_edge (
      .core_clk(core_clk),
      .rst(rst),
      .level_in(cw_reg[cw_seq_pkg::BIT_FAULT_RESET]),
      .pulse_out(cw_reset_edge)
   );

   // The same edge detector serves the digital-input reset source.
   rise_pulse u_ext_reset_edge (
      .core_clk(core_clk),
      .rst(rst),
      .level_in(ext_fault_reset),
      .pulse_out(ext_reset_edge)
   );

   assign any_reset = cw_reset_edge | ext_reset_edge;

   // Next state: faults take priority over every command value.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         cw_seq_pkg::ST_FAULT: begin
            if (any_reset && !fault_present) begin
               state_next = cw_seq_pkg::ST_NOT_READY;
            end
         end
         cw_seq_pkg::ST_NOT_READY: begin
            if (fault_present) begin
               state_next = cw_seq_pkg::ST_FAULT;
            end else if (cw_write && cw_next == cw_seq_pkg::CMD_SWITCH_ON) begin
               state_next = cw_seq_pkg::ST_READY_SWITCH_ON;
            end
         end
         cw_seq_pkg::ST_READY_SWITCH_ON: begin
            if (fault_present) begin
               state_next = cw_seq_pkg::ST_FAULT;
            end else if (cw_write && cw_next == cw_seq_pkg::CMD_OPERATE) begin
               state_next = cw_seq_pkg::ST_READY_OPERATE;
            end
         end
         cw_seq_pkg::ST_READY_OPERATE: begin
            // Ramp words are refused here: the drive must be enabled before the ramp is freed.
            if (fault_present) begin
               state_next = cw_seq_pkg::ST_FAULT;
            end else if (cw_write) begin
               if (cw_next == cw_seq_pkg::CMD_SWITCH_ON) begin
                  state_next = cw_seq_pkg::ST_READY_SWITCH_ON;
               end else if (cw_next == cw_seq_pkg::CMD_ENABLE) begin
                  state_next = cw_seq_pkg::ST_OP_ENABLED;
               end
            end
         end
         cw_seq_pkg::ST_OP_ENABLED,
         cw_seq_pkg::ST_ACCEL_ENABLED,
         cw_seq_pkg::ST_OPERATING: begin
            // Running states step forward on their word and fall back on an earlier one.
            if (fault_present) begin
               state_next = cw_seq_pkg::ST_FAULT;
            end else if (cw_write) begin
               if (cw_next == cw_seq_pkg::CMD_SWITCH_ON) begin
                  state_next = cw_seq_pkg::ST_READY_SWITCH_ON;
               end else if (cw_next == cw_seq_pkg::CMD_OPERATE) begin
                  state_next = cw_seq_pkg::ST_READY_OPERATE;
               end else if (cw_next == cw_seq_pkg::CMD_ENABLE) begin
                  state_next = cw_seq_pkg::ST_OP_ENABLED;
               end else if (cw_next == cw_seq_pkg::CMD_ACCEL) begin
                  state_next = cw_seq_pkg::ST_ACCEL_ENABLED;
               end else if (cw_next == cw_seq_pkg::CMD_RUN) begin
                  state_next = cw_seq_pkg::ST_OPERATING;
               end
            end
         end
         default: begin
            // The one unused code sends the machine back to the power-up state.
            state_next = cw_seq_pkg::ST_NOT_READY;
         end
      endcase
   end

   // State register; reset always lands in not-ready-to-switch-on.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= cw_seq_pkg::ST_NOT_READY;
      end else begin
         state_reg <= state_next;
      end
   end

   // Settling timer restarts on entry to ready-to-switch-on. The host owns the wait;
   // the device only reports whether it was respected.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         settle_cnt_reg <= 32'h00000000;
         settle_done_reg <= 1'b0;
      end else if (state_next == cw_seq_pkg::ST_READY_SWITCH_ON &&
                   state_reg != cw_seq_pkg::ST_READY_SWITCH_ON) begin
         settle_cnt_reg <= 32'h00000000;
         settle_done_reg <= 1'b0;
      end else if (state_reg == cw_seq_pkg::ST_READY_SWITCH_ON && !settle_done_reg) begin
         settle_cnt_reg <= settle_cnt_reg + 32'h00000001;
         // The flag rises on the edge that completes SETTLE_COUNT whole cycles in the state.
         settle_done_reg <= (settle_cnt_reg + 32'h00000001) >= 32'(SETTLE_COUNT);
      end
   end

   // Sticky flag for any write other than the switch-on word made before the dwell ran out; cleared by reset only.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         early_write_seen <= 1'b0;
      end else if (state_reg == cw_seq_pkg::ST_READY_SWITCH_ON && cw_write && !settle_done_reg &&
                   cw_next != cw_seq_pkg::CMD_SWITCH_ON) begin
         early_write_seen <= 1'b1;
      end
   end

   // Start acceptance ignores the run permissive but needs every interlock.
   assign start_ok = cmd_start && !interlock_missing && state_reg != cw_seq_pkg::ST_FAULT;
   assign run_ok = start_ok && !cmd_run_inhibit;
   assign running_state = state_reg == cw_seq_pkg::ST_OP_ENABLED ||
                          state_reg == cw_seq_pkg::ST_ACCEL_ENABLED ||
                          state_reg == cw_seq_pkg::ST_OPERATING;

   // Start status. Acceptance ignores the run permissive, so a host may start before granting it.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         start_accepted <= 1'b0;
         run_permitted <= 1'b0;
      end else begin
         start_accepted <= start_ok;
         run_permitted <= !cmd_run_inhibit;
      end
   end

   // Plain field mirrors of the stored word, one cycle behind it.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         network_takeover_request <= 1'b0;
         start_interlock_one_inhibit <= 1'b0;
         start_interlock_two_inhibit <= 1'b0;
         start_interlock_three_inhibit <= 1'b0;
         start_interlock_four_inhibit <= 1'b0;
         override_two_select <= 1'b0;
      end else begin
         network_takeover_request <= cw_reg[cw_seq_pkg::BIT_TAKEOVER];
         start_interlock_one_inhibit <= cmd_interlocks[0];
         start_interlock_two_inhibit <= cmd_interlocks[1];
         start_interlock_three_inhibit <= cmd_interlocks[2];
         start_interlock_four_inhibit <= cmd_interlocks[3];
         override_two_select <= cw_reg[cw_seq_pkg::BIT_OVERRIDE];
      end
   end

   // Fault reset strobe, one cycle wide whichever source gave the edge.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fault_reset_pulse <= 1'b0;
      end else begin
         fault_reset_pulse <= any_reset;
      end
   end

   // Ramp control follows the sequence, taken from the next state so it moves with state_code.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ramp_generator_release <= 1'b0;
         ramp_generator_accel <= 1'b0;
      end else begin
         ramp_generator_release <= state_next == cw_seq_pkg::ST_ACCEL_ENABLED ||
                                   state_next == cw_seq_pkg::ST_OPERATING;
         ramp_generator_accel <= state_next == cw_seq_pkg::ST_OPERATING;
      end
   end

   // In system mode the selected drive profile only shapes the ramp hold bit; start logic
   // stays on the bypass word whatever profile is chosen.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ramp_hold_out <= 1'b0;
      end else begin
         ramp_hold_out <= system_mode & drive_profile_ramp_hold;
      end
   end

   // Bypass path start. Outside system mode the bypass word drives it on its own.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bypass_start <= 1'b0;
      end else if (system_mode) begin
         bypass_start <= run_ok && running_state && bypass_mode;
      end else begin
         bypass_start <= run_ok && running_state;
      end
   end

   // Drive path start. Outside system mode the drive node obeys its own network start;
   // in system mode that request is dropped and the bypass word starts the drive path while bypass_mode is low.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         drive_start <= 1'b0;
      end else if (system_mode) begin
         drive_start <= run_ok && running_state && !bypass_mode;
      end else begin
         drive_start <= drive_start_request;
      end
   end

   // Read-back: live link bit in place of the stored one, reserved bits zero. It shows the word
   // written on the same edge, so a host reading straight after a write sees its own value.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         command_word_read <= cw_seq_pkg::CW_RESET;
      end else begin
         command_word_read <= cw_next | (16'(link_up) << cw_seq_pkg::BIT_LINK);
      end
   end

   // State code, taken from the next state so it moves together with the state register.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_code <= 3'(cw_seq_pkg::ST_NOT_READY);
      end else begin
         state_code <= 3'(state_next);
      end
   end

   // Dwell report, one cycle behind the internal flag.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         settle_done <= 1'b0;
      end else begin
         settle_done <= settle_done_reg;
      end
   end

endmodule

// ==== src/cw_seq_pkg.sv ====
// Purpose: Shared constants and types for the bypass command word sequencer.
// Assumes: A 10 MHz core clock and a 16-bit command word.
// Notes: Command values are full 16-bit patterns compared after reserved bits are cleared.
package cw_seq_pkg;

   // Width of the command word.
   localparam int CW_WIDTH = 16;

   // Bit positions inside the command word.
   localparam int BIT_START = 0;
   localparam int BIT_FAULT_RESET = 1;
   localparam int BIT_RUN_INHIBIT = 2;
   localparam int BIT_TAKEOVER = 3;
   localparam int BIT_INTERLOCK_LO = 4;
   localparam int BIT_INTERLOCK_HI = 7;
   localparam int BIT_OVERRIDE = 8;
   localparam int BIT_LINK = 9;

   // Bits that software may store; bit 9 and bits 10 to 15 are excluded.
   localparam logic [15:0] WRITABLE_MASK = 16'h01FF;
   localparam logic [15:0] CW_RESET = 16'h0000;

   // Sequence command values.
   localparam logic [15:0] CMD_SWITCH_ON = 16'h0006;
   localparam logic [15:0] CMD_OPERATE = 16'h0007;
   localparam logic [15:0] CMD_ENABLE = 16'h000F;
   localparam logic [15:0] CMD_ACCEL = 16'h002F;
   localparam logic [15:0] CMD_RUN = 16'h006F;

   // Least settling time after reaching ready-to-switch-on.
   localparam int CLK_HZ = 10_000_000;
   localparam int SETTLE_MS = 100;
   localparam int SETTLE_CYCLES = (CLK_HZ / 1000) * SETTLE_MS;

   // Sequencer states.
   typedef enum logic [2:0] {
      ST_NOT_READY,
      ST_READY_SWITCH_ON,
      ST_READY_OPERATE,
      ST_OP_ENABLED,
      ST_ACCEL_ENABLED,
      ST_OPERATING,
      ST_FAULT
   } seq_state_t;

endpackage

// ==== src/rise_pulse.sv ====
// Purpose: One-cycle pulse on a rising edge of a synchronous level.
// Assumes: The input is already synchronous to core_clk.
// Notes: The history flop clears on reset so a level held high through reset gives a pulse.
module rise_pulse (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic level_in,
   output logic pulse_out
);

   logic last_reg;

   // Keep the previous sample and flag a low-to-high step.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         last_reg <= 1'b0;
         pulse_out <= 1'b0;
      end else begin
         last_reg <= level_in;
         pulse_out <= level_in & ~last_reg;
      end
   end

endmodule

// ==== verification/cw_seq_asserts.sv ====
// Purpose: Port-level assertions for the command word sequencer.
// Assumes: One clock core_clk and a synchronous active-high rst.
// Notes: History checks wait two edges after reset so past values are real.
module cw_seq_asserts (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cw_write,
   input wire logic [15:0] cw_write_data,
   input wire logic link_up,
   input wire logic fault_present,
   input wire logic ext_fault_reset,
   input wire logic system_mode,
   input wire logic drive_start_request,
   input wire logic drive_profile_ramp_hold,
   input wire logic [15:0] command_word_read,
   input wire logic [2:0] state_code,
   input wire logic ramp_generator_release,
   input wire logic ramp_generator_accel,
   input wire logic fault_reset_pulse,
   input wire logic run_permitted,
   input wire logic start_accepted,
   input wire logic network_takeover_request,
   input wire logic override_two_select,
   input wire logic drive_start,
   input wire logic ramp_hold_out
);
   logic [1:0] age;
   logic ok;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Edge count since reset, so that reset leftovers never feed a past value.
   always_ff @(posedge core_clk) begin
      if (rst) age <= 2'h0;
      else if (age != 2'h2) age <= age + 2'h1;
   end
   assign ok = (age == 2'h2);
   property p_power_up; $fell(rst) |-> state_code == 3'h0; endproperty
   a_power_up: assert property (p_power_up) else $error("state not idle after reset");
   property p_switch_on;
      ok && cw_write && cw_write_data == 16'h0006 && !fault_present && state_code != 3'h6 |=> state_code == 3'h1;
   endproperty
   a_switch_on: assert property (p_switch_on) else $error("switch-on word not obeyed");
   property p_ready_op;
      ok && cw_write && cw_write_data == 16'h0007 && !fault_present && state_code == 3'h1 |=> state_code == 3'h2;
   endproperty
   a_ready_op: assert property (p_ready_op) else $error("operate word not obeyed");
   property p_ramp;
      {ramp_generator_release, ramp_generator_accel} == {state_code == 3'h4 || state_code == 3'h5, state_code == 3'h5};
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp outputs disagree with state");
   property p_reserved; command_word_read[15:10] == 6'h00; endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
   property p_link; ok |-> command_word_read[9] == $past(link_up); endproperty
   a_link: assert property (p_link) else $error("link bit does not follow link");
   property p_fields;
      ok |-> {run_permitted, network_takeover_request, override_two_select} ==
         {!$past(command_word_read[2]), $past(command_word_read[3]), $past(command_word_read[8])};
   endproperty
   a_fields: assert property (p_fields) else $error("field output wrong");
   property p_interlock; ok && start_accepted |-> $past(command_word_read[7:4]) == 4'h0; endproperty
   a_interlock: assert property (p_interlock) else $error("start accepted with interlock missing");
   property p_reset_edge;
      ok && ($rose(command_word_read[1]) || $rose(ext_fault_reset)) |-> ##[1:2] fault_reset_pulse;
   endproperty
   a_reset_edge: assert property (p_reset_edge) else $error("reset edge gave no pulse");
   property p_ramp_hold; ok |-> ramp_hold_out == $past(system_mode & drive_profile_ramp_hold); endproperty
   a_ramp_hold: assert property (p_ramp_hold) else $error("ramp hold not routed");
   property p_drive_route;
      ok && !system_mode && !$past(system_mode) |-> drive_start == $past(drive_start_request);
   endproperty
   a_drive_route: assert property (p_drive_route) else $error("drive start not passed through");
   c_operating: cover property (state_code == 3'h5);
   c_reset_pulse: cover property (fault_reset_pulse);
   c_system_drive: cover property (system_mode && drive_start);
endmodule

bind bypass_control_word_sequencer cw_seq_asserts chk_u (.*);

// ==== verification/net_host.sv ====
// Purpose: Network host model that writes command words to the sequencer.
// Assumes: Writes launch on the falling edge of core_clk.
// Notes: Idle data lines toggle so a stale word is never taken for a write.
module net_host #(
   parameter int DWELL = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic req,
   input wire logic [15:0] word,
   output logic ack,
   output logic cw_write,
   output logic [15:0] cw_write_data
);
   int wait_cnt = 0;
   // Idle values at time zero.
   initial begin
      ack = 1'b0;
      cw_write = 1'b0;
      cw_write_data = 16'h0000;
   end
   // One write per request; the dwell after the switch-on word keeps the start order legal.
   always @(negedge core_clk) begin
      if (!rst && wait_cnt == 0 && req && !ack) begin
         cw_write <= 1'b1;
         cw_write_data <= word;
      end else begin
         cw_write <= 1'b0;
         cw_write_data <= ~cw_write_data;
      end
      if (rst) begin
         ack <= 1'b0;
         wait_cnt <= 0;
      end else begin
         if (!req) ack <= 1'b0;
         if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
         else if (req && !ack) begin
            ack <= 1'b1;
            if (word == 16'h0006) wait_cnt <= DWELL + 4;
         end
      end
   end
endmodule

// ==== verification/bypass_control_word_sequencer_bench.sv ====
// Purpose: Self-checking bench for the command word sequencer.
// Assumes: Inputs change on the falling edge; settle count shortened to DWELL.
// Notes: Each write is followed by three edges so every registered output has landed.
module bypass_control_word_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DWELL = 8;
   logic core_clk = 1'b0, rst = 1'b1, req = 1'b0, link_up = 1'b1, fault_present = 1'b0;
   logic ext_fault_reset = 1'b0, system_mode = 1'b0, bypass_mode = 1'b0;
   logic drive_start_request = 1'b0, drive_profile_ramp_hold = 1'b0;
   logic cw_write, ack, settle_done, early_write_seen, ramp_generator_release, ramp_generator_accel;
   logic fault_reset_pulse, run_permitted, start_accepted, network_takeover_request, override_two_select;
   logic start_interlock_one_inhibit, start_interlock_two_inhibit, start_interlock_three_inhibit;
   logic start_interlock_four_inhibit, bypass_start, drive_start, ramp_hold_out;
   logic [15:0] word = 16'h0000, cw_write_data, command_word_read;
   logic [2:0] state_code;
   logic [3:0] inh;
   int n_errors = 0, check_count = 0;
   // The four interlock outputs gathered, bit 0 first.
   assign inh = {start_interlock_four_inhibit, start_interlock_three_inhibit,
      start_interlock_two_inhibit, start_interlock_one_inhibit};
   // A 10 MHz clock.
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   bypass_control_word_sequencer #(.SETTLE_COUNT(DWELL)) dut_u (.*);
   net_host #(.DWELL(DWELL)) host_u (.*);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Hands one word to the host and waits, bounded, for it to be sent.
   task automatic wr(input logic [15:0] w);
      int i;
      word <= w;
      req <= 1'b1;
      for (i = 0; i < 50 && ack !== 1'b1; i++) @(negedge core_clk);
      if (ack !== 1'b1) begin
         n_errors++;
         complete_run();
      end
      req <= 1'b0;
      repeat (3) @(negedge core_clk);
   endtask
   task automatic t_seq();
      chk(state_code, 3'h0);
      wr(16'h0006);
      chk(state_code, 3'h1);
      chk(command_word_read, 16'h0206);
      // The write edge lies 3.5 cycles back; the report follows the dwell by one cycle.
      repeat (DWELL - 3) @(negedge core_clk);
      chk(settle_done, 1'b0);
      @(negedge core_clk);
      chk(settle_done, 1'b1);
      wr(16'h0007);
      chk(state_code, 3'h2);
      wr(16'h000F);
      chk({state_code, bypass_start}, 4'h6);
      wr(16'h002F);
      chk({state_code, ramp_generator_release, ramp_generator_accel}, 5'h12);
      wr(16'h006F);
      chk({state_code, ramp_generator_release, ramp_generator_accel}, 5'h17);
      chk(early_write_seen, 1'b0);
      wr(16'h0001);
      chk({state_code, bypass_start}, 4'hB);
      wr(16'h0000);
      chk({state_code, bypass_start}, 4'hA);
      $display("test sequence done");
   endtask
   task automatic t_fields();
      wr(16'hFFFF);
      chk(command_word_read, 16'h03FF);
      chk({run_permitted, start_accepted, network_takeover_request, override_two_select}, 4'h3);
      chk(inh, 4'hF);
      link_up <= 1'b0;
      wr(16'h0005);
      chk(command_word_read, 16'h0005);
      chk({run_permitted, start_accepted, inh}, 6'h10);
      link_up <= 1'b1;
      $display("test fields done");
   endtask
   task automatic t_fault();
      fault_present <= 1'b1;
      repeat (3) @(negedge core_clk);
      fault_present <= 1'b0;
      chk(state_code, 3'h6);
      wr(16'h0002);
      chk(state_code, 3'h0);
      fault_present <= 1'b1;
      repeat (3) @(negedge core_clk);
      fault_present <= 1'b0;
      wr(16'h0002);
      chk(state_code, 3'h6);
      ext_fault_reset <= 1'b1;
      repeat (4) @(negedge core_clk);
      chk(state_code, 3'h0);
      ext_fault_reset <= 1'b0;
      $display("test fault done");
   endtask
   task automatic t_route();
      system_mode <= 1'b1;
      drive_start_request <= 1'b1;
      drive_profile_ramp_hold <= 1'b1;
      wr(16'h0006);
      wr(16'h0007);
      wr(16'h000F);
      chk({drive_start, bypass_start, ramp_hold_out}, 3'h1);
      wr(16'h0001);
      chk({drive_start, bypass_start, ramp_hold_out}, 3'h5);
      bypass_mode <= 1'b1;
      repeat (3) @(negedge core_clk);
      chk({drive_start, bypass_start}, 2'h1);
      system_mode <= 1'b0;
      repeat (3) @(negedge core_clk);
      chk({drive_start, ramp_hold_out}, 2'h2);
      $display("test routing done");
   endtask
   // Reset for eight cycles, then the scenarios in turn.
   initial begin
      repeat (8) @(negedge core_clk);
      rst <= 1'b0;
      repeat (2) @(negedge core_clk);
      t_seq();
      t_fields();
      t_fault();
      t_route();
      complete_run();
   end
endmodule
